// *** ith_i2c_host.sv ***
// I2C host that reads external temperature sensors, with its AHB-Lite registers.
//
// Summary of operation
// - Sensor address chosen by illumination channel.
// - Per-frame trigger launches sequence each frame sync.
// - Manual trigger write launches one sequence.
// - Count field: one or two transactions.
// - Direction bits: low first, high second.
// - Per-transaction byte count: one or two.
// - Writes send first then second write byte.
// - Select picks one byte of read data.
// - Selected read byte readable by software.
// - Enabled readout refreshes temperatures after each averaged set of reads.
// - Three sensors, one per illumination channel.
// - Each sensor read is one or two bytes.
// - Readout enable stores sensor temperatures.
// - Averaging code: 0 none, 2 four readings.
// - Position setting picks 12 of 16 bits.
// - 12-bit mode, else 8-bit sensor data.
// - Reading taken as linear, no correction.
// - Own host data and clock line pair.
`timescale 1ns/1ps
`default_nettype none
module ith_i2c_host #(
  parameter int QDIV = ith_pkg::QUARTER_CYC  // Clock cycles per quarter bit.
) (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic [31:0]       hrdata,
  output var  logic              hreadyout,
  output var  logic              hresp,
  input  wire logic              frame_sync,
  input  wire logic [1:0]        illum_channel,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output var  logic              scl_o,
  output var  logic              scl_oe,
  output var  logic              sda_o,
  output var  logic              sda_oe,
  output var  ith_pkg::ith_temp_s ext_temp,
  output var  logic              busy
);
  import ith_pkg::*;

  // Configuration fields written by software.
  logic [1:0]  rw_r;         // Direction of each transaction.
  logic        host_en_r;    // Host enable.
  logic        mtrig_r;      // Manual trigger bit as last written.
  logic        ftrig_r;      // Per-frame trigger.
  logic [6:0]  sa0_r, sa1_r, sa2_r;  // Sensor addresses of channels 0, 1 and 2.
  logic        rd_en_r;      // External temperature readout enable.
  logic [1:0]  avg_r;        // Averaging code.
  logic        ntran_r;      // Second transaction wanted.
  logic [7:0]  wb1_r, wb2_r;    // First and second write bytes.
  logic [1:0]  cnt1_r, cnt2_r;  // Byte counts of the two transactions.
  logic [1:0]  sel_r;        // Read byte select.
  logic [3:0]  msb_r;        // Extraction position.
  logic        twb_r;        // 12-bit mode.
  // Bus slave state.
  logic        wr_pend_r;    // A write data phase is under way.
  logic [7:0]  wr_idx_r;     // Register index of that write.
  logic [7:0]  acc_idx;      // Register index of the current address phase.
  logic        acc_take;     // Address phase accepted this cycle.
  logic [31:0] rd_mux;       // Read value for the current address phase.
  logic        wr_go;        // Write lands this cycle.
  // Link state.
  ith_state_e  state_r;      // Sequencer state.
  logic [1:0]  ph_r;         // Quarter phase within a bit.
  logic [3:0]  bit_r;        // Bit in byte; 8 is the acknowledge slot.
  logic [1:0]  byte_r;       // 0 is the address byte, then data bytes.
  logic        txn_r;        // Current transaction.
  logic [7:0]  sh_r;         // Byte being sent or received.
  logic        ack_r;        // Line level seen in the acknowledge slot.
  logic [31:0] rdata_r;      // Collected read data, newest byte lowest.
  logic        nack_r;       // Last sequence was refused.
  logic [1:0]  ch_r;         // Channel latched at launch.
  logic        fs_q_r;       // Frame sync of the previous cycle.
  logic        tick;         // Quarter-bit enable.
  // Temperature filter state per channel.
  logic [14:0] sum_r [3];    // Sum of readings so far.
  logic [2:0]  num_r [3];    // Readings summed so far.
  // Decoded helpers.
  logic        cur_rw, cur_two;  // Direction and two-byte count of this transaction.
  logic        last_byte;    // Current byte is the final one.
  logic        reading;      // Current byte is driven by the sensor.
  logic        go, mtrig_go; // Launch now; software wrote a manual trigger.
  logic [6:0]  sa_cur;       // Address of the latched channel.
  logic [11:0] t_new;        // Temperature from the finished read.
  logic [14:0] t_sum;        // Sum including the new reading.
  logic        scl_s, sda_s; // Synchronised clock and data lines.
  // Clock stretching and reads both look at the lines only after two stages.
  ith_sync #(.W(2)) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .d        ({scl_i, sda_i}),
    .q        ({scl_s, sda_s})
  );
  // The divider only runs while a sequence is active.
  ith_tick #(.DIV(QDIV)) u_tick (
    .core_clk (core_clk),
    .resetn   (resetn),
    .run      (busy),
    .tick     (tick)
  );
  // Address phase decode; anything above the map is unmapped.
  assign acc_take = hsel & htrans[1] & hready;
  assign acc_idx  = (haddr[31:10] == 22'h0) ? haddr[9:2] : REG_NONE_IDX;
  assign wr_go    = wr_pend_r;
  assign mtrig_go = wr_go & (wr_idx_r == REG_CTRL_IDX) & hwdata[CTRL_MTRIG_BIT];
  // Read multiplexer; unused bits and unmapped addresses read as zero.
  always_comb begin
    rd_mux = 32'h0;
    case (acc_idx)
      REG_CTRL_IDX: begin
        rd_mux[CTRL_RW_LSB +: 2] = rw_r;
        rd_mux[CTRL_EN_BIT]      = host_en_r;
        rd_mux[CTRL_MTRIG_BIT]   = mtrig_r;
        rd_mux[CTRL_FTRIG_BIT]   = ftrig_r;
      end
      REG_ADDR_IDX: begin
        rd_mux[6:0]                = sa0_r;
        rd_mux[ADDR_CH1_LSB +: 7]  = sa1_r;
        rd_mux[ADDR_CH2_LSB +: 7]  = sa2_r;
        rd_mux[ADDR_RDEN_BIT]      = rd_en_r;
        rd_mux[ADDR_AVG_LSB +: 2]  = avg_r;
      end
      REG_XFER_IDX: begin
        rd_mux[7:0]                = rdata_r[sel_r*8 +: 8];
        rd_mux[XFER_WB1_LSB +: 8]  = wb1_r;
        rd_mux[XFER_NTRAN_BIT]     = ntran_r;
      end
      REG_CNT2_IDX: rd_mux[CNT2_LSB +: 2] = cnt2_r;
      REG_DATA2_IDX: begin
        rd_mux[7:0]                  = wb2_r;
        rd_mux[DATA2_CNT1_LSB +: 2]  = cnt1_r;
        rd_mux[DATA2_SEL_LSB +: 2]   = sel_r;
      end
      REG_TCFG_IDX: begin
        rd_mux[3:0]          = msb_r;
        rd_mux[TCFG_TWB_BIT] = twb_r;
      end
      REG_TEMP0_IDX:        rd_mux[11:0] = ext_temp.ch[0];
      REG_TEMP0_IDX + 8'h1: rd_mux[11:0] = ext_temp.ch[1];
      REG_TEMP0_IDX + 8'h2: rd_mux[11:0] = ext_temp.ch[2];
      REG_STAT_IDX:         rd_mux[1:0]  = {nack_r, busy};
      default:              rd_mux = 32'h0;
    endcase
  end
  // Bus answer: zero wait states, always OKAY, read data held in a flop.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= REG_NONE_IDX;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_r <= acc_take & hwrite;
      wr_idx_r  <= acc_idx;
      hrdata    <= (acc_take & ~hwrite) ? rd_mux : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  // Register writes land in the data phase.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rw_r <= 2'h0; host_en_r <= 1'b0; mtrig_r <= 1'b0; ftrig_r <= 1'b0;
      sa0_r <= SENSOR_ADDR_RST; sa1_r <= SENSOR_ADDR_RST; sa2_r <= SENSOR_ADDR_RST;
      rd_en_r <= 1'b0; avg_r <= 2'h0; ntran_r <= 1'b0; wb1_r <= 8'h0;
      wb2_r <= 8'h0; cnt1_r <= 2'h0; cnt2_r <= 2'h0; sel_r <= 2'h0;
      msb_r <= MSB_POS_RST; twb_r <= 1'b0;
    end else if (wr_go) begin
      case (wr_idx_r)
        REG_CTRL_IDX: begin
          rw_r      <= hwdata[CTRL_RW_LSB +: 2];
          host_en_r <= hwdata[CTRL_EN_BIT];
          mtrig_r   <= hwdata[CTRL_MTRIG_BIT];
          ftrig_r   <= hwdata[CTRL_FTRIG_BIT];
        end
        REG_ADDR_IDX: begin
          sa0_r   <= hwdata[6:0];
          sa1_r   <= hwdata[ADDR_CH1_LSB +: 7];
          sa2_r   <= hwdata[ADDR_CH2_LSB +: 7];
          rd_en_r <= hwdata[ADDR_RDEN_BIT];
          avg_r   <= hwdata[ADDR_AVG_LSB +: 2];
        end
        REG_XFER_IDX: begin
          wb1_r   <= hwdata[XFER_WB1_LSB +: 8];
          ntran_r <= hwdata[XFER_NTRAN_BIT];
        end
        REG_CNT2_IDX: cnt2_r <= hwdata[CNT2_LSB +: 2];
        REG_DATA2_IDX: begin
          wb2_r  <= hwdata[7:0];
          cnt1_r <= hwdata[DATA2_CNT1_LSB +: 2];
          sel_r  <= hwdata[DATA2_SEL_LSB +: 2];
        end
        REG_TCFG_IDX: begin
          msb_r <= hwdata[3:0];
          twb_r <= hwdata[TCFG_TWB_BIT];
        end
        default: ;  // Read-only or unmapped: the write is dropped.
      endcase
    end
  end
  // Launch decode: enable needed and a running sequence is never cut short.
  assign go = host_en_r & (state_r == ST_IDLE)
            & (mtrig_go | (ftrig_r & frame_sync & ~fs_q_r));
  // Per-transaction view of the configuration.
  assign cur_rw    = txn_r ? rw_r[1] : rw_r[0];
  assign cur_two   = txn_r ? cnt2_r[0] : cnt1_r[0];
  assign last_byte = (byte_r == (cur_two ? 2'd2 : 2'd1));
  assign reading   = cur_rw & (byte_r != 2'd0);
  // The address follows the channel latched at launch.
  assign sa_cur = (ch_r == 2'd1) ? sa1_r : (ch_r == 2'd2) ? sa2_r : sa0_r;
  // Frame sync edge memory.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fs_q_r <= 1'b0;
    end else begin
      fs_q_r <= frame_sync;
    end
  end
  // Link sequencer; lines are open drain, so only low is ever driven.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE; ph_r <= 2'd0; bit_r <= 4'd0; byte_r <= 2'd0;
      txn_r <= 1'b0; sh_r <= 8'h0; ack_r <= 1'b1; rdata_r <= 32'h0;
      nack_r <= 1'b0; ch_r <= 2'd0; busy <= 1'b0;
      scl_oe <= 1'b0; sda_oe <= 1'b0; scl_o <= 1'b0; sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          if (go) begin
            state_r <= ST_START;
            busy    <= 1'b1;
            ph_r    <= 2'd0;
            txn_r   <= 1'b0;
            nack_r  <= 1'b0;
            rdata_r <= 32'h0;
            ch_r    <= (illum_channel == 2'd3) ? 2'd0 : illum_channel; // Channel 3 uses 0.
          end
        end
        ST_START: if (tick) begin
          // Both lines high, data falls, then clock falls.
          ph_r <= ph_r + 2'd1;
          case (ph_r)
            2'd0: begin scl_oe <= 1'b0; sda_oe <= 1'b0; end
            2'd1: sda_oe <= 1'b1;
            2'd2: scl_oe <= 1'b1;
            default: begin
              state_r <= ST_BIT;
              bit_r   <= 4'd0;
              byte_r  <= 2'd0;
              sh_r    <= {sa_cur, cur_rw};
            end
          endcase
        end
        ST_BIT: if (tick) begin
          case (ph_r)
            2'd0: begin
              // Clock low: set up the data line.
              scl_oe <= 1'b1;
              ph_r   <= 2'd1;
              sda_oe <= (bit_r != 4'd8) ? (~reading & ~sh_r[7]) : (reading & ~last_byte);
            end
            2'd1: begin
              scl_oe <= 1'b0;
              ph_r   <= 2'd2;
            end
            2'd2: if (scl_s) begin
              // Sample only once the clock is truly high.
              ph_r <= 2'd3;
              if (bit_r != 4'd8) sh_r <= {sh_r[6:0], sda_s};
              else ack_r <= sda_s;
            end
            default: begin
              scl_oe <= 1'b1;
              ph_r   <= 2'd0;
              if (bit_r != 4'd8) bit_r <= bit_r + 4'd1;
              else if (!reading && ack_r) begin
                // No acknowledge from the sensor: abandon with a stop.
                nack_r  <= 1'b1;
                state_r <= ST_STOP;
              end else begin
                if (reading) rdata_r <= {rdata_r[23:0], sh_r};
                if (last_byte) begin
                  state_r <= ST_STOP;
                end else begin
                  byte_r <= byte_r + 2'd1;
                  bit_r  <= 4'd0;
                  sh_r   <= (byte_r == 2'd0) ? wb1_r : wb2_r;
                end
              end
            end
          endcase
        end
        ST_STOP: if (tick) begin
          // Clock and data low, clock rises, then data rises.
          ph_r <= ph_r + 2'd1;
          case (ph_r)
            2'd0: begin scl_oe <= 1'b1; sda_oe <= 1'b1; end
            2'd1: scl_oe <= 1'b0;
            2'd2: sda_oe <= 1'b0;
            default: begin
              if (!nack_r && !txn_r && ntran_r) begin
                txn_r   <= 1'b1;
                state_r <= ST_START;
              end else begin
                state_r <= ST_IDLE;
                busy    <= 1'b0;
              end
            end
          endcase
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // New temperature: the code is taken as linear, no correction table.
  always_comb begin
    t_new = (twb_r && cur_two) ? ith_extract(rdata_r[15:0], msb_r)
                               : {rdata_r[7:0], 4'h0};
    t_sum = sum_r[ch_r] + {3'h0, t_new};
  end
  // Store results as a sequence ends cleanly after a read.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ext_temp <= '0;
      for (int i = 0; i < 3; i++) begin
        sum_r[i] <= 15'h0;
        num_r[i] <= 3'h0;
      end
    end else if (state_r == ST_STOP && tick && ph_r == 2'd3 && !nack_r
                 && cur_rw && rd_en_r && !(!txn_r && ntran_r)) begin
      if (num_r[ch_r] == 3'((4'h1 << avg_r) - 4'h1)) begin
        ext_temp.ch[ch_r] <= 12'(t_sum >> avg_r);
        sum_r[ch_r]       <= 15'h0;
        num_r[ch_r]       <= 3'h0;
      end else begin
        sum_r[ch_r] <= t_sum;
        num_r[ch_r] <= num_r[ch_r] + 3'h1;
      end
    end
  end
  // The size field is accepted for any width; every access is a whole word.
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[1:0]};

endmodule : ith_i2c_host
`default_nettype wire

// *** ith_pkg.sv ***
// Constants, types and helpers shared by the temperature-sensor I2C host.
package ith_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] REG_CTRL_IDX  = 8'h01;  // Direction, enable and triggers.
  localparam logic [7:0] REG_ADDR_IDX  = 8'h02;  // Sensor addresses, readout setup.
  localparam logic [7:0] REG_XFER_IDX  = 8'h03;  // Read data, first write byte, count.
  localparam logic [7:0] REG_CNT2_IDX  = 8'h05;  // Second transaction byte count.
  localparam logic [7:0] REG_DATA2_IDX = 8'h07;  // Second write byte, count, select.
  localparam logic [7:0] REG_TCFG_IDX  = 8'h10;  // Extraction position, 12-bit mode.
  localparam logic [7:0] REG_TEMP0_IDX = 8'h11;  // Channel 0 result; 1 and 2 follow.
  localparam logic [7:0] REG_STAT_IDX  = 8'h14;  // Busy and no-acknowledge flags.
  localparam logic [7:0] REG_NONE_IDX  = 8'hFF;  // Marks an access outside the map.

  // Field positions.
  localparam int CTRL_FTRIG_BIT = 17;
  localparam int CTRL_MTRIG_BIT = 18;
  localparam int CTRL_EN_BIT    = 19;
  localparam int CTRL_RW_LSB    = 20;
  localparam int ADDR_CH1_LSB   = 7;
  localparam int ADDR_CH2_LSB   = 14;
  localparam int ADDR_RDEN_BIT  = 21;
  localparam int ADDR_AVG_LSB   = 22;
  localparam int XFER_WB1_LSB   = 9;
  localparam int XFER_NTRAN_BIT = 17;
  localparam int CNT2_LSB       = 22;
  localparam int DATA2_CNT1_LSB = 16;
  localparam int DATA2_SEL_LSB  = 18;
  localparam int TCFG_TWB_BIT   = 4;

  // Values after reset.
  localparam logic [6:0] SENSOR_ADDR_RST = 7'h48;
  localparam logic [3:0] MSB_POS_RST     = 4'h0;

  // Bus timing: four quarter ticks make one bit on the link.
  localparam int CLK_KHZ     = 25000;
  localparam int LINK_KHZ    = 100;
  localparam int QUARTER_CYC = (CLK_KHZ + 4 * LINK_KHZ - 1) / (4 * LINK_KHZ);

  // Link sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} ith_state_e;

  // Stored temperature of each illumination channel.
  typedef struct packed {
    logic [2:0][11:0] ch;
  } ith_temp_s;

  // Pick 12 bits of a 16-bit reading whose top bit sits at pos + 7; below pos 4, bits 11 to 0.
  function automatic logic [11:0] ith_extract(input logic [15:0] v, input logic [3:0] pos);
    logic [3:0] sh;
    sh = (pos >= 4'h4) ? pos - 4'h4 : 4'h0;
    return 12'(v >> sh);
  endfunction : ith_extract

endpackage : ith_pkg

// *** ith_sync.sv ***
// Two-stage synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module ith_sync #(
  parameter int W = 2  // Number of bits carried.
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;  // First stage, read by the second stage only.

  // Both stages idle high, as a released open-drain line does.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : ith_sync
`default_nettype wire

// *** ith_tick.sv ***
// Divider giving a one-cycle enable pulse every DIV clock cycles.
`timescale 1ns/1ps
`default_nettype none
module ith_tick #(
  parameter int DIV = 63  // Cycles between pulses.
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic run,
  output var  logic tick
);

  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;  // Cycles since the last pulse.

  // The count restarts while idle so the first tick is a full period away.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end

endmodule : ith_tick
`default_nettype wire

// *** ith_i2c_host_assertions.sv ***
// Port checker for the temperature-sensor I2C host.
`timescale 1ns/1ps
`default_nettype none
module ith_i2c_host_assertions #(
  parameter int QDIV = 4  // Clock cycles per quarter bit.
) (
  input wire logic        core_clk, resetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic        frame_sync, scl_i, scl_o, scl_oe, sda_o, sda_oe, busy,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire ith_pkg::ith_temp_s ext_temp
);
  import ith_pkg::*;
  localparam int QW = 2 * QDIV;  // Longest wait from start to the first low clock.
  logic       wr_ctrl_r;         // A control write was taken last cycle.
  logic       en_r;              // Host enable as last written.
  logic       fs_r;              // Frame sync one cycle ago.
  logic [3:0] since_r;           // Cycles since the last trigger, saturating.
  wire        cause = (wr_ctrl_r && hwdata[CTRL_MTRIG_BIT]) || (frame_sync && !fs_r);
  // Tracks control writes and recent trigger causes.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ctrl_r <= 1'b0;
      en_r      <= 1'b0;
      fs_r      <= 1'b0;
      since_r   <= 4'hF;
    end else begin
      wr_ctrl_r <= hsel && htrans[1] && hready && hwrite && haddr == {22'h0, REG_CTRL_IDX, 2'h0};
      en_r      <= wr_ctrl_r ? hwdata[CTRL_EN_BIT] : en_r;
      fs_r      <= frame_sync;
      since_r   <= cause ? 4'h0 : since_r + {3'h0, since_r != 4'hF};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus not ready or not OKAY");
  chk_rdata_zero:
    assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
      else $error("read data outside a data phase");
  chk_open_drain:
    assert property (!scl_o && !sda_o) else $error("line driven high");
  chk_idle_free:
    assert property (!busy |-> !scl_oe && !sda_oe) else $error("line held while idle");
  chk_trig_launch:
    assert property (wr_ctrl_r && hwdata[CTRL_MTRIG_BIT] && hwdata[CTRL_EN_BIT] && en_r
      && !busy |-> ##[1:3] busy) else $error("manual trigger did not launch");
  chk_busy_cause:
    assert property ($rose(busy) |-> since_r <= 4'h6) else $error("run without trigger");
  chk_start_clk:
    assert property ($rose(sda_oe) && !scl_oe && scl_i |-> ##[1:QW] scl_oe)
      else $error("no clock after start");
  chk_run_min:
    assert property ($rose(busy) |-> busy [*8]) else $error("run ended too soon");
  chk_temp_run:
    assert property ($changed(ext_temp) |-> busy || $past(busy))
      else $error("temperature changed while idle");
  cov_manual: cover property (wr_ctrl_r && hwdata[CTRL_MTRIG_BIT] ##[1:3] $rose(busy));
  cov_frame: cover property (frame_sync && !fs_r ##[1:6] $rose(busy));
  cov_temp: cover property ($changed(ext_temp));
endmodule : ith_i2c_host_assertions
bind ith_i2c_host ith_i2c_host_assertions #(.QDIV(QDIV)) u_chk (.core_clk(core_clk),
  .resetn(resetn), .hsel(hsel), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .frame_sync(frame_sync), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy), .htrans(htrans), .haddr(haddr),
  .hwdata(hwdata), .hrdata(hrdata), .ext_temp(ext_temp));
`default_nettype wire

// *** ith_sensor_model.sv ***
// Behavioural temperature sensor on the host's I2C lines.
`timescale 1ns/1ps
`default_nettype none
module ith_sensor_model (
  input  wire logic       scl,       // Clock line level.
  input  wire logic       sda,       // Data line level.
  input  wire logic [6:0] addr,      // Own bus address.
  input  wire logic       slow,      // Stretch the clock after the address.
  output var  logic       sda_pull,  // High pulls the data line low.
  output var  logic       scl_pull   // High pulls the clock line low.
);
  logic [7:0]  b;               // Byte being shifted in.
  logic [15:0] val = 16'hABC0;  // Next reading; steps by 1111h per read.
  logic [7:0]  got[$];          // Bytes written by the host.
  int          k;               // Byte index within a read.
  initial begin
    sda_pull = 1'h0;
    scl_pull = 1'h0;
  end
  // Shifts in eight bits on rising clocks.
  task automatic rx8;
    repeat (8) @(posedge scl) b = {b[6:0], sda};
  endtask : rx8
  // One frame after a start; a stop ends it anywhere.
  initial forever begin : frame
    @(negedge sda iff scl === 1'h1);
    rx8;
    @(negedge scl) sda_pull = (b[7:1] == addr);
    if (slow) begin
      scl_pull = 1'h1;
      #600 scl_pull = 1'h0;
    end
    if (b[7:1] != addr) @(posedge sda);
    else if (b[0]) begin
      k = 0;
      do begin
        for (int i = 7; i >= 0; i--) @(negedge scl) sda_pull = !(k[0] ? val[i] : val[8 + i]);
        @(negedge scl) sda_pull = 1'h0;
        @(posedge scl) k++;
      end while (sda === 1'h0);
      val = val + 16'h1111;
    end else forever begin
      @(negedge scl) sda_pull = 1'h0;
      rx8;
      got.push_back(b);
      @(negedge scl) sda_pull = 1'h1;
    end
  end
  // A stop releases the data line and restarts the frame.
  always @(posedge sda) begin
    if (scl === 1'h1) begin
      sda_pull = 1'h0;
      disable frame;
    end
  end
endmodule : ith_sensor_model
`default_nettype wire

// *** ith_i2c_host_test.sv ***
// Testbench driving the I2C host registers against a sensor model.
`timescale 1ns/1ps
`default_nettype none
module ith_i2c_host_test;
  import ith_pkg::*;
  logic        core_clk, resetn, hsel, hwrite, frame_sync, slow;
  logic [1:0]  htrans, illum_channel;
  logic [31:0] haddr, hwdata, hrdata, rdata_q;
  logic        hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, busy, sda_pull, scl_pull;
  ith_temp_s   ext_temp;
  int          bad_count, n_checks;
  wire         scl = !(scl_oe || scl_pull);  // Pull-ups hold released lines high.
  wire         sda = !(sda_oe || sda_pull);
  ith_i2c_host #(.QDIV(4)) dut (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frame_sync(frame_sync), .illum_channel(illum_channel), .scl_i(scl), .sda_i(sda),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .ext_temp(ext_temp),
    .busy(busy));
  ith_sensor_model mdl (.scl(scl), .sda(sda), .addr(7'h4A), .slow(slow),
    .sda_pull(sda_pull), .scl_pull(scl_pull));
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = !core_clk;
  end
  // Compares a value seen with the one expected.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One AHB-Lite single transfer; read data lands in rdata_q.
  task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'h0};
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    rdata_q = hrdata;
  endtask : ahb
  task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input string what);
    ahb(1'h0, idx, 32'h0);
    check(rdata_q, e, what);
  endtask : rchk
  // Waits, bounded, for a run to start and to end.
  task automatic run_wait;
    int n;
    for (n = 0; busy !== 1'h1 && n < 40; n++) @(posedge core_clk);
    check({31'h0, busy}, 32'h1, "busy rise");
    for (n = 0; busy !== 1'h0 && n < 8000; n++) @(posedge core_clk);
    check({31'h0, busy}, 32'h0, "busy fall");
  endtask : run_wait
  // Pulses frame sync and checks the stored channel 1 temperature.
  task automatic frame(input logic [11:0] t, input string what);
    frame_sync <= 1'h1;
    @(posedge core_clk);
    frame_sync <= 1'h0;
    run_wait;
    check({20'h0, ext_temp.ch[1]}, {20'h0, t}, what);
  endtask : frame
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Cuts a hang short well past the expected run length.
  initial begin
    #2400000;
    bad_count++;
    close_out;
  end
  initial begin
    {resetn, hsel, hwrite, frame_sync, slow} = 5'h0;
    {htrans, haddr, hwdata} = 66'h0;
    illum_channel = 2'h1;
    repeat (10) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    rchk(REG_ADDR_IDX, 32'h122448, "address reset");
    rchk(8'h30, 32'h0, "unmapped");
    ahb(1'h1, REG_TEMP0_IDX, 32'hFFF);
    rchk(REG_TEMP0_IDX, 32'h0, "read-only");
    ahb(1'h1, REG_CTRL_IDX, 32'h40000);
    repeat (20) @(posedge core_clk);
    check({31'h0, busy}, 32'h0, "disabled trigger");
    ahb(1'h1, REG_ADDR_IDX, 32'h122548);
    ahb(1'h1, REG_XFER_IDX, 32'h34A00);
    ahb(1'h1, REG_DATA2_IDX, 32'h1003C);
    ahb(1'h1, REG_CTRL_IDX, 32'h280000);
    ahb(1'h1, REG_CTRL_IDX, 32'h2C0000);
    ahb(1'h1, REG_CTRL_IDX, 32'h2C0000);
    run_wait;
    check(mdl.got.size(), 32'h2, "bytes written");
    check({24'h0, mdl.got[0]}, 32'hA5, "write byte 1");
    check({24'h0, mdl.got[1]}, 32'h3C, "write byte 2");
    rchk(REG_XFER_IDX, 32'h34AAB, "one-byte read");
    check({20'h0, ext_temp.ch[1]}, 32'h0, "readout off");
    slow <= 1'h1;
    ahb(1'h1, REG_ADDR_IDX, 32'h322548);
    ahb(1'h1, REG_TCFG_IDX, 32'h18);
    ahb(1'h1, REG_CNT2_IDX, 32'h400000);
    ahb(1'h1, REG_CTRL_IDX, 32'h3C0000);
    run_wait;
    for (int s = 0; s < 4; s++) begin
      ahb(1'h1, REG_DATA2_IDX, 32'h1003C | (s << 18));
      rchk(REG_XFER_IDX, 32'h34A00 | (32'hBCD1CDE2 >> (8 * s)) & 32'hFF, "select");
    end
    check({20'h0, ext_temp.ch[1]}, 32'hCDE, "12-bit temp");
    rchk(8'h12, 32'hCDE, "temp register");
    slow <= 1'h0;
    ahb(1'h1, REG_XFER_IDX, 32'h14A00);
    ahb(1'h1, REG_CTRL_IDX, 32'h1A0000);
    frame(12'hDEF, "frame temp");
    ahb(1'h1, REG_TCFG_IDX, 32'h8);
    ahb(1'h1, REG_DATA2_IDX, 32'h3C);
    frame(12'hF00, "8-bit temp");
    illum_channel <= 2'h2;
    ahb(1'h1, REG_CTRL_IDX, 32'h1C0000);
    run_wait;
    rchk(REG_STAT_IDX, 32'h2, "nack flag");
    check({20'h0, ext_temp.ch[2]}, 32'h0, "no update");
    close_out;
  end
endmodule : ith_i2c_host_test
`default_nettype wire
